// file: verilog/qpsync_pkg.sv
package qpsync_pkg;

  localparam int NUM_PORTS = 4;

  // Clock multiplier field encodings
  localparam logic [1:0] MULT_1X    = 2'h0;
  localparam logic [1:0] MULT_2X    = 2'h1;
  localparam logic [1:0] MULT_4X    = 2'h2;
  localparam logic [1:0] MULT_RESET = 2'h0;

  // Loopback mode encodings
  localparam logic [1:0] LOOP_OFF    = 2'h0;
  localparam logic [1:0] LOOP_RECOV  = 2'h1;
  localparam logic [1:0] LOOP_DIRECT = 2'h2;

  // Cell-side interface selection by mode pins
  localparam logic [1:0] CIF_MPHY8   = 2'h0;
  localparam logic [1:0] CIF_L2BUS16 = 2'h1;
  localparam logic [1:0] CIF_NIBBLE4 = 2'h2;

  // Symbol sync thresholds, in received symbols
  localparam logic [3:0] LOCK_GOOD_CNT = 4'h8;
  localparam logic [3:0] LOSE_BAD_CNT  = 4'h4;
  localparam logic [3:0] CNT_RESET     = 4'h0;

  // Escape symbol, which marks a cell start or a timing marker pair
  localparam logic [4:0] ESCAPE_SYM = 5'h15;

  localparam int CELL_DEPTH = 3;

  typedef enum logic [2:0] {
    QPSYNC_HUNT  = 3'h1,
    QPSYNC_CHECK = 3'h2,
    QPSYNC_LOCK  = 3'h4
  } qpsync_state_t;

  typedef struct packed {
    logic       sym_valid;
    logic [4:0] sym;
  } qpsync_sym_t;

  typedef struct packed {
    logic       good_signal;
    logic       rx_buf_en;
    logic       marker_seen;
    logic [3:0] slip_cnt;
  } qpsync_stat_t;

endpackage

// file: verilog/qpsync_port.sv
module qpsync_port (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  input  wire logic                  bit_in,
  input  wire logic                  bit_valid,
  output qpsync_pkg::qpsync_stat_t   stat,
  output qpsync_pkg::qpsync_sym_t    sym_out
);

  // ==========================================================
  // Symbol validity
  function automatic logic sym_ok(input logic [4:0] s);
    // Data symbols and escape; everything else is a line code violation
    case (s)
      5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D,
      5'h11: sym_ok = 1'b1;
      default: sym_ok = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Shifter and symbol phase
  logic [4:0]                 shift_r;
  logic [2:0]                 phase_r;
  logic                       sym_stb;
  logic                       slip;
  logic [3:0]                 good_r;
  logic [3:0]                 bad_r;
  qpsync_pkg::qpsync_state_t  state_r;

  assign sym_stb = bit_valid && (phase_r == 3'h4);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_r <= 5'h00;
      phase_r <= 3'h0;
    end else if (ce && bit_valid) begin
      shift_r <= {shift_r[3:0], bit_in};
      // Slip holds phase one bit so any valid stream aligns
      if (slip)
        phase_r <= phase_r;
      else if (phase_r == 3'h4)
        phase_r <= 3'h0;
      else
        phase_r <= phase_r + 3'h1;
    end
  end

  wire logic [4:0] cur_sym = {shift_r[3:0], bit_in};
  wire logic       cur_ok  = sym_ok(cur_sym);

  // ==========================================================
  // Sync state machine: lock on any valid symbols, not only escapes
  assign slip = sym_stb && !cur_ok && (state_r == qpsync_pkg::QPSYNC_HUNT);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= qpsync_pkg::QPSYNC_HUNT;
      good_r  <= qpsync_pkg::CNT_RESET;
      bad_r   <= qpsync_pkg::CNT_RESET;
    end else if (ce && sym_stb) begin
      case (state_r)
        qpsync_pkg::QPSYNC_HUNT: begin
          good_r <= qpsync_pkg::CNT_RESET;
          if (cur_ok)
            state_r <= qpsync_pkg::QPSYNC_CHECK;
        end
        qpsync_pkg::QPSYNC_CHECK: begin
          // Idle data symbols count too, no cells needed
          if (!cur_ok) begin
            state_r <= qpsync_pkg::QPSYNC_HUNT;
          end else if (good_r == qpsync_pkg::LOCK_GOOD_CNT - 4'h2) begin
            state_r <= qpsync_pkg::QPSYNC_LOCK;
            bad_r   <= qpsync_pkg::CNT_RESET;
          end else begin
            good_r <= good_r + 4'h1;
          end
        end
        qpsync_pkg::QPSYNC_LOCK: begin
          // Consecutive violations mean loss of signal
          if (cur_ok)
            bad_r <= qpsync_pkg::CNT_RESET;
          else if (bad_r == qpsync_pkg::LOSE_BAD_CNT - 4'h1)
            state_r <= qpsync_pkg::QPSYNC_HUNT;
          else
            bad_r <= bad_r + 4'h1;
        end
        default: state_r <= qpsync_pkg::QPSYNC_HUNT;
      endcase
    end
  end

  // ==========================================================
  // Outputs
  logic [3:0] slips_r;
  logic       marker_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slips_r  <= qpsync_pkg::CNT_RESET;
      marker_r <= 1'b0;
      sym_out  <= '0;
    end else if (ce) begin
      if (slip && slips_r != 4'hF)
        slips_r <= slips_r + 4'h1;
      marker_r        <= sym_stb && (state_r == qpsync_pkg::QPSYNC_LOCK)
                         && (cur_sym == qpsync_pkg::ESCAPE_SYM);
      sym_out.sym_valid <= sym_stb && (state_r == qpsync_pkg::QPSYNC_LOCK);
      sym_out.sym       <= cur_sym;
    end
  end

  // Good signal and buffer enable follow lock directly
  assign stat.good_signal = (state_r == qpsync_pkg::QPSYNC_LOCK);
  // Gate for the cell buffer; the three-cell stores sit outside this block
  assign stat.rx_buf_en   = (state_r == qpsync_pkg::QPSYNC_LOCK);
  assign stat.marker_seen = marker_r;
  assign stat.slip_cnt    = slips_r;

endmodule

// file: verilog/qpsync_top.sv
// Function
// - Align 4b/5b symbols from any valid stream
// - Align without cells or timing markers
// - Set good signal while valid signal received
// - On loss, clear good signal, disable buffer
// - Line rate is reference times field multiplier
// - Shared reference, independent per-port multiplier
// - Direct loopback only at 1x multiplier
// - Coding identical at every multiplier
// - Mode pins pick cell-side interface
// - Per-port buffer enable; the three-cell stores sit outside
// - Control bits stand in for the 8-bit muxed-bus registers
// - Marker insert and extract pins
module qpsync_top (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [1:0]  mode_pins,
  // Control bits stand in for the muxed-bus registers
  input  wire logic [7:0]  mult_sel,
  input  wire logic [7:0]  loop_sel,
  input  wire logic [3:0]  marker_in,
  input  wire logic [3:0]  rx_bit,
  input  wire logic [3:0]  rx_bit_valid,
  output logic      [1:0]  cell_if_sel,
  output logic      [7:0]  mult_r,
  output logic      [3:0]  rate_tick,
  output logic      [3:0]  loop_direct_ok,
  output logic      [3:0]  good_signal,
  output logic      [3:0]  rx_buf_en,
  output logic      [3:0]  rx_frame_marker_out,
  output logic      [3:0]  tx_marker_insert,
  output logic      [19:0] rx_sym,
  output logic      [3:0]  rx_sym_valid
);

  // ==========================================================
  // Cell-side interface and per-port multipliers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      cell_if_sel <= qpsync_pkg::CIF_MPHY8;
    else if (ce)
      cell_if_sel <= (mode_pins == 2'h3) ? qpsync_pkg::CIF_MPHY8 : mode_pins;
  end

  // Reserved code 11 falls back to 1x rather than stopping the port
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mult_r <= {4{qpsync_pkg::MULT_RESET}};
    end else if (ce) begin
      for (int i = 0; i < qpsync_pkg::NUM_PORTS; i++)
        mult_r[2*i +: 2] <= (mult_sel[2*i +: 2] == 2'h3) ? qpsync_pkg::MULT_1X
                                                           : mult_sel[2*i +: 2];
    end
  end

  // ==========================================================
  // Rate ticks: clk is the 4x line clock; each port divides independently
  logic [1:0] div_r [qpsync_pkg::NUM_PORTS];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < qpsync_pkg::NUM_PORTS; i++)
        div_r[i] <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < qpsync_pkg::NUM_PORTS; i++)
        div_r[i] <= div_r[i] + 2'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < qpsync_pkg::NUM_PORTS; i++) begin
      case (mult_r[2*i +: 2])
        qpsync_pkg::MULT_4X: rate_tick[i] = 1'b1;
        qpsync_pkg::MULT_2X: rate_tick[i] = (div_r[i][0] == 1'b1);
        default:             rate_tick[i] = (div_r[i] == 2'h3);
      endcase
      // Direct loopback is honoured only at base rate
      loop_direct_ok[i] = (loop_sel[2*i +: 2] == qpsync_pkg::LOOP_DIRECT)
                          && (mult_r[2*i +: 2] == qpsync_pkg::MULT_1X);
    end
  end

  // ==========================================================
  // Per-port symbol sync, same coding at every rate
  qpsync_pkg::qpsync_stat_t stat [qpsync_pkg::NUM_PORTS];
  qpsync_pkg::qpsync_sym_t  syms [qpsync_pkg::NUM_PORTS];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_port
      qpsync_port u_port (
        .clk       (clk),
        .resetn    (resetn),
        .ce        (ce),
        .bit_in    (rx_bit[g]),
        .bit_valid (rx_bit_valid[g] && rate_tick[g]),
        .stat      (stat[g]),
        .sym_out   (syms[g])
      );
      assign good_signal[g]         = stat[g].good_signal;
      assign rx_buf_en[g]           = stat[g].rx_buf_en;
      assign rx_sym[5*g +: 5]       = syms[g].sym;
      assign rx_sym_valid[g]        = syms[g].sym_valid;
    end
  endgenerate

  // ==========================================================
  // Timing marker insert and extract
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_frame_marker_out <= 4'h0;
      tx_marker_insert    <= 4'h0;
    end else if (ce) begin
      for (int i = 0; i < qpsync_pkg::NUM_PORTS; i++) begin
        rx_frame_marker_out[i] <= stat[i].marker_seen;
        tx_marker_insert[i]    <= marker_in[i];
      end
    end
  end

  // ==========================================================
  // Checks
  chk_good_clears_buf: assert property (@(posedge clk) disable iff (!resetn)
    good_signal == rx_buf_en) else $error("buffer enable differs from good signal");

  chk_reset_mult_1x: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> mult_r == 8'h00) else $error("multiplier not 1x after reset");

  chk_mult_follow: assert property (@(posedge clk) disable iff (!resetn)
    ce && mult_sel[1:0] == 2'h2 |=> mult_r[1:0] == 2'h2)
    else $error("port 0 multiplier not taken");

  chk_rate_4x_tick: assert property (@(posedge clk) disable iff (!resetn)
    mult_r[1:0] == qpsync_pkg::MULT_4X |-> rate_tick[0]) else $error("4x not every clock");

  chk_rate_1x_gap: assert property (@(posedge clk) disable iff (!resetn)
    mult_r[1:0] == qpsync_pkg::MULT_1X && rate_tick[0] && ce
      && mult_sel[1:0] != qpsync_pkg::MULT_2X && mult_sel[1:0] != qpsync_pkg::MULT_4X
      |=> !rate_tick[0]) else $error("1x tick too dense");

  chk_loop_direct_1x: assert property (@(posedge clk) disable iff (!resetn)
    loop_direct_ok[0] |-> mult_r[1:0] == 2'h0) else $error("direct loop above 1x");

  chk_if_select: assert property (@(posedge clk) disable iff (!resetn)
    ce && mode_pins == 2'h2 |=> cell_if_sel == qpsync_pkg::CIF_NIBBLE4)
    else $error("nibble interface not selected");

  chk_marker_pass: assert property (@(posedge clk) disable iff (!resetn)
    ce && marker_in[0] |=> tx_marker_insert[0]) else $error("marker not inserted");

  chk_sym_needs_good: assert property (@(posedge clk) disable iff (!resetn)
    rx_sym_valid[0] |-> $past(good_signal[0])) else $error("symbol out without lock");

endmodule

// file: verification/qpsync_line_src.sv
module qpsync_line_src (
  input  wire logic clk,
  input  wire logic tick,
  input  wire logic run,
  input  wire logic bad,
  input  wire logic esc,
  output logic      bit_out,
  output logic      bit_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Far-end transmitter, one symbol bit per tick
  logic [4:0] tbl [4] = '{5'h1E, 5'h09, 5'h14, 5'h0A};
  int         k = 0;
  initial begin
    bit_out   = 1'b0;
    bit_valid = 1'b0;
  end
  // Idle data codes, the escape symbol while esc is set, zeros while bad, MSB first
  // A released line toggles so a stale bit never looks valid
  always @(negedge clk) begin
    if (!run) begin
      bit_valid <= 1'b0;
      bit_out   <= ~bit_out;
    end else if (tick) begin
      bit_valid <= 1'b1;
      // Escape symbols model timing marker pairs on request
      bit_out   <= bad ? 1'b0 :
                   esc ? qpsync_pkg::ESCAPE_SYM[4 - (k % 5)] : tbl[(k / 5) % 4][4 - (k % 5)];
      k         <= k + 1;
    end
  end
endmodule

// file: verification/qpsync_top_tb.sv
module qpsync_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        ce = 1'b1;
  logic [1:0]  mode_pins = 2'h0;
  logic [7:0]  mult_sel = 8'h00;
  logic [7:0]  loop_sel = 8'h00;
  logic [3:0]  marker_in = 4'h0;
  logic [3:0]  run = 4'h0;
  logic [3:0]  bad = 4'h0;
  logic [3:0]  esc = 4'h0;
  logic [3:0]  rx_bit, rx_bit_valid, rate_tick, loop_direct_ok, good_signal;
  logic [3:0]  rx_buf_en, rx_frame_marker_out, tx_marker_insert, rx_sym_valid;
  logic [1:0]  cell_if_sel;
  logic [7:0]  mult_r;
  logic [19:0] rx_sym;
  int          error_cnt = 0;
  int          num_checks = 0;

  // One clock stands for a reference inside 32 to 64 MHz times four
  // No register bus here, so address capture by strobe is not modelled
  // No marker pulse-width field exists; markers are single pulses
  initial begin
    forever #2 clk = ~clk;
  end

  qpsync_top dut (.clk(clk), .resetn(resetn), .ce(ce), .mode_pins(mode_pins),
    .mult_sel(mult_sel), .loop_sel(loop_sel), .marker_in(marker_in), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .cell_if_sel(cell_if_sel), .mult_r(mult_r),
    .rate_tick(rate_tick), .loop_direct_ok(loop_direct_ok), .good_signal(good_signal),
    .rx_buf_en(rx_buf_en), .rx_frame_marker_out(rx_frame_marker_out),
    .tx_marker_insert(tx_marker_insert), .rx_sym(rx_sym), .rx_sym_valid(rx_sym_valid));

  for (genvar g = 0; g < 4; g++) begin : g_src
    qpsync_line_src src (.clk(clk), .tick(rate_tick[g] & ce), .run(run[g]), .bad(bad[g]),
      .esc(esc[g]),
      .bit_out(rx_bit[g]), .bit_valid(rx_bit_valid[g]));
  end

  // ==========================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_rate();
    int cnt [4];
    int exp [4] = '{4, 8, 16, 4};
    mult_sel = {2'h3, qpsync_pkg::MULT_4X, qpsync_pkg::MULT_2X, qpsync_pkg::MULT_1X};
    repeat (2) @(negedge clk);
    chk(mult_r, 8'h24);
    cnt = '{0, 0, 0, 0};
    repeat (16) begin
      for (int i = 0; i < 4; i++) cnt[i] += rate_tick[i];
      @(negedge clk);
    end
    for (int i = 0; i < 4; i++) chk(cnt[i], exp[i]);
  endtask

  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      mode_pins = m[1:0];
      repeat (2) @(negedge clk);
      chk(cell_if_sel, (m == 3) ? 2'h0 : m[1:0]);
    end
  endtask

  task automatic t_loop();
    loop_sel = {4{qpsync_pkg::LOOP_DIRECT}};
    @(negedge clk);
    chk(loop_direct_ok, 4'h9);
    loop_sel = {4{qpsync_pkg::LOOP_RECOV}};
    @(negedge clk);
    chk(loop_direct_ok, 4'h0);
  endtask

  task automatic t_marker();
    chk(tx_marker_insert, 4'h0);
    marker_in = 4'hA;
    @(negedge clk);
    chk(tx_marker_insert, 4'hA);
    marker_in = 4'h0;
    @(negedge clk);
    chk(tx_marker_insert, 4'h0);
  endtask

  task automatic t_lock();
    int n = 0;
    run = 4'hF;
    while (good_signal !== 4'hF && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk(good_signal, 4'hF);
    chk(rx_buf_en, 4'hF);
    n = 0;
    // One symbol every five cycles at 4x
    repeat (20) begin
      @(negedge clk);
      n += rx_sym_valid[2];
    end
    chk(n, 4);
  endtask

  task automatic t_loss();
    int n = 0;
    bad = 4'h4;
    while (good_signal[2] !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(good_signal, 4'hB);
    chk(rx_buf_en, 4'hB);
    bad = 4'h0;
    n = 0;
    while (good_signal !== 4'hF && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(good_signal, 4'hF);
  endtask

  task automatic t_esc();
    int n = 0;
    esc = 4'h4;
    repeat (10) @(negedge clk);
    repeat (20) begin
      n += rx_frame_marker_out[2];
      chk(rx_frame_marker_out & 4'hB, 4'h0);
      if (rx_sym_valid[2]) chk(rx_sym[14:10], 5'h15);
      @(negedge clk);
    end
    chk(n, 4);
    chk(good_signal, 4'hF);
    esc = 4'h0;
  endtask

  task automatic t_hold();
    ce = 1'b0;
    mult_sel[1:0] = qpsync_pkg::MULT_4X;
    repeat (3) @(negedge clk);
    chk(mult_r, 8'h24);
    chk(good_signal, 4'hF);
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk(mult_r, 8'h26);
    resetn = 1'b0;
    @(negedge clk);
    chk(mult_r, 8'h00);
    chk(good_signal, 4'h0);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    chk(mult_r, 8'h26);
  endtask

  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (4) @(negedge clk);
    chk(mult_r, 8'h00);
    chk(good_signal, 4'h0);
    resetn = 1'b1;
    @(negedge clk);
    t_rate();
    t_mode();
    t_loop();
    t_marker();
    t_lock();
    t_esc();
    t_loss();
    t_hold();
    end_sim();
  end
endmodule
